// file: pkg/acmp_pkg.sv
// Purpose: Constants and types of the three-comparator control block
// Assumes: 32-bit classic Wishbone register port, byte addresses
// Notes:   Control registers hold eight bits in the low byte of a word
package acmp_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int ACMP_NUM = 3;
    localparam int ACMP_AW = 5;
    localparam int ACMP_DW = 32;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [ACMP_AW-1:0] ACMP_OFS_CTRL1 = 5'h00;
    localparam logic [ACMP_AW-1:0] ACMP_OFS_CTRL2 = 5'h04;
    localparam logic [ACMP_AW-1:0] ACMP_OFS_CTRL3 = 5'h08;
    localparam logic [ACMP_AW-1:0] ACMP_OFS_STAT = 5'h0C;
    localparam logic [ACMP_AW-1:0] ACMP_OFS_EVFLAG = 5'h10;
    localparam logic [ACMP_AW-1:0] ACMP_OFS_IRQST = 5'h14;
    localparam logic [ACMP_AW-1:0] ACMP_OFS_IRQMSK = 5'h18;

    // ---------------------------------------------------------------
    // Control register fields and reset value
    // ---------------------------------------------------------------
    localparam logic [7:0] ACMP_CTRL_RST = 8'h1F;

    localparam logic [1:0] ACMP_EV_OFF = 2'h0;
    localparam logic [1:0] ACMP_EV_RISE = 2'h1;
    localparam logic [1:0] ACMP_EV_FALL = 2'h2;
    localparam logic [1:0] ACMP_EV_ANY = 2'h3;

    localparam logic [1:0] ACMP_NSEL_DEF = 2'h0;
    localparam logic [1:0] ACMP_NSEL_C = 2'h1;
    localparam logic [1:0] ACMP_NSEL_B2 = 2'h2;
    localparam logic [1:0] ACMP_NSEL_BG = 2'h3;

    // Resolved negative-input route, one per comparator
    localparam logic [1:0] ACMP_ROUTE_B2 = 2'h0;
    localparam logic [1:0] ACMP_ROUTE_C = 2'h1;
    localparam logic [1:0] ACMP_ROUTE_D = 2'h2;
    localparam logic [1:0] ACMP_ROUTE_BG = 2'h3;

    // Index of comparator two, which defaults to its D pin
    localparam int ACMP_IDX_D = 1;

    typedef struct packed {
        logic enable;
        logic output_pin_enable;
        logic output_invert;
        logic [1:0] event_edge_select;
        logic noninverting_source_select;
        logic [1:0] inverting_input_select;
    } acmp_ctrl_t;

    // Analog front-end steering for one comparator
    typedef struct packed {
        logic enable;
        logic pos_ladder;
        logic [1:0] neg_route;
    } acmp_analog_t;

endpackage

// file: src/acmp_ctrl.sv
// Purpose: Control, status and event logic for three analog comparators
// Assumes: Raw comparator outputs are asynchronous; Wishbone is synchronous
// Notes:   Analog muxes sit outside and are steered by analog_o
// Behaviour
// - Three comparators, separate control registers
// - Top control bit enables comparator
// - Pin enable drives result onto pin
// - Invert bit flips result everywhere used
// - Edge select picks rise, fall, any, none
// - Selecting any-change mode sets flag immediately
// - Positive input ladder reference or pin A
// - Negative input bandgap, B2, C, default
// - Default: comparators one, three B2; two D
// - Status low three bits, upper zero
// - Status one when adjusted result high
// - Raw output high when positive exceeds negative
// - Reset clears top three, sets lower five
// - Flag cleared by zero, set by one
// - Flag set regardless of interrupt enables
// - Edge detection uses polarity-adjusted output
// - Sleep keeps registers; enabled events wake
`timescale 1ns/100ps
module acmp_ctrl
    import acmp_pkg::*;
(
    input wire logic clk_i,                            // System clock
    input wire logic rst_i,                            // Sync reset, high
    input wire logic wb_cyc_i,                         // Bus cycle
    input wire logic wb_stb_i,                         // Bus strobe
    input wire logic wb_we_i,                          // Write
    input wire logic [ACMP_AW-1:0] wb_adr_i,           // Byte address
    input wire logic [ACMP_DW/8-1:0] wb_sel_i,         // Byte lanes
    input wire logic [ACMP_DW-1:0] wb_dat_i,           // Write data
    output logic [ACMP_DW-1:0] wb_dat_o,               // Read data
    output logic wb_ack_o,                             // Acknowledge
    input wire logic [ACMP_NUM-1:0] comparator_raw_i,  // Raw analog results
    input wire logic sleep_i,                          // Device in sleep
    output acmp_analog_t [ACMP_NUM-1:0] analog_o,      // Analog steering
    output logic [ACMP_NUM-1:0] result_pin_o,          // Pin output value
    output logic [ACMP_NUM-1:0] result_pin_oe_o,       // Pin driven
    output logic [ACMP_NUM-1:0] comparator_event_flag_o, // Event flags
    output logic wake_o,                               // Wake from sleep
    output logic irq_o                                 // Level interrupt
);

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    logic ack_q;
    logic [ACMP_DW-1:0] rdat_q;
    logic [ACMP_DW-1:0] rdat_d;
    wire req = wb_cyc_i & wb_stb_i;
    wire wr_fire = req & ack_q & wb_we_i & wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire hit_evflag = wb_adr_i == ACMP_OFS_EVFLAG;
    wire hit_irqst = wb_adr_i == ACMP_OFS_IRQST;
    wire hit_irqmsk = wb_adr_i == ACMP_OFS_IRQMSK;
    wire wr_evflag = wr_fire & hit_evflag;
    wire wr_irqst = wr_fire & hit_irqst;
    wire wr_irqmsk = wr_fire & hit_irqmsk;

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ---------------------------------------------------------------
    // Per-comparator state
    // ---------------------------------------------------------------
    acmp_ctrl_t ctrl_q [ACMP_NUM];
    logic [ACMP_NUM-1:0] sync1_q;
    logic [ACMP_NUM-1:0] sync2_q;
    logic [ACMP_NUM-1:0] adj_prev_q;
    logic [ACMP_NUM-1:0] adj;
    logic [ACMP_NUM-1:0] event_hit;
    logic [ACMP_NUM-1:0] evflag_q;
    logic [ACMP_NUM-1:0] evflag_d;
    logic [ACMP_NUM-1:0] irqst_q;
    logic [ACMP_NUM-1:0] irqmsk_q;
    logic [ACMP_NUM-1:0] pin_q;
    logic [ACMP_NUM-1:0] pin_oe_q;

    // ---------------------------------------------------------------
    // Synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        sync1_q <= comparator_raw_i;
        sync2_q <= sync1_q;
    end

    genvar gi;
    generate
        for (gi = 0; gi < ACMP_NUM; gi++) begin : g_cmp
            localparam logic [ACMP_AW-1:0] OFS_STEP = ACMP_OFS_CTRL2 - ACMP_OFS_CTRL1;
            localparam logic [ACMP_AW-1:0] OFS = ACMP_OFS_CTRL1 + ACMP_AW'(gi) * OFS_STEP;
            wire wr_ctrl = wr_fire & (wb_adr_i == OFS);
            wire acmp_ctrl_t wr_val = acmp_ctrl_t'(wbyte);
            wire any_sel = wr_ctrl & (wr_val.event_edge_select == ACMP_EV_ANY);
            wire [1:0] es = ctrl_q[gi].event_edge_select;
            wire rise = adj[gi] & ~adj_prev_q[gi];
            wire fall = ~adj[gi] & adj_prev_q[gi];
            wire [1:0] dflt = (gi == ACMP_IDX_D) ? ACMP_ROUTE_D : ACMP_ROUTE_B2;
            logic [1:0] route;

            // Raw high means positive above negative; disabled reads low
            assign adj[gi] = ctrl_q[gi].enable & (sync2_q[gi] ^ ctrl_q[gi].output_invert);

            // Edge qualification on adjusted value; enables play no part
            assign event_hit[gi] = any_sel
                | ((es == ACMP_EV_RISE) & rise)
                | ((es == ACMP_EV_FALL) & fall)
                | ((es == ACMP_EV_ANY) & (rise | fall));

            always_comb begin
                case (ctrl_q[gi].inverting_input_select)
                    ACMP_NSEL_BG: route = ACMP_ROUTE_BG;
                    ACMP_NSEL_B2: route = ACMP_ROUTE_B2;
                    ACMP_NSEL_C: route = ACMP_ROUTE_C;
                    default: route = dflt;
                endcase
            end

            assign analog_o[gi].enable = ctrl_q[gi].enable;
            assign analog_o[gi].pos_ladder = ctrl_q[gi].noninverting_source_select;
            assign analog_o[gi].neg_route = route;

            // Set wins over clear: software zero, hardware event
            assign evflag_d[gi] = wr_evflag ? (wbyte[gi] | event_hit[gi])
                                            : (evflag_q[gi] | event_hit[gi]);

            // Sleep does not touch control contents
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctrl_q[gi] <= acmp_ctrl_t'(ACMP_CTRL_RST);
                end else if (wr_ctrl) begin
                    ctrl_q[gi] <= wr_val;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Flags, interrupt, pin
    // ---------------------------------------------------------------
    logic [ACMP_NUM-1:0] pin_en;
    logic [ACMP_NUM-1:0] en_vec;
    logic [ACMP_NUM-1:0] evsel_on;
    always_comb begin
        for (int i = 0; i < ACMP_NUM; i++) begin
            pin_en[i] = ctrl_q[i].output_pin_enable;
            en_vec[i] = ctrl_q[i].enable;
            evsel_on[i] = ctrl_q[i].event_edge_select != ACMP_EV_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adj_prev_q <= '0;
            evflag_q <= '0;
            irqst_q <= '0;
            irqmsk_q <= '0;
            pin_q <= '0;
            pin_oe_q <= '0;
        end else begin
            adj_prev_q <= adj;
            evflag_q <= evflag_d;
            irqst_q <= (irqst_q & ~(wr_irqst ? wbyte[ACMP_NUM-1:0] : '0)) | event_hit;
            if (wr_irqmsk) begin
                irqmsk_q <= wbyte[ACMP_NUM-1:0];
            end
            pin_q <= adj & pin_en;
            pin_oe_q <= pin_en;
        end
    end

    assign comparator_event_flag_o = evflag_q;
    assign result_pin_o = pin_q;
    assign result_pin_oe_o = pin_oe_q;
    assign irq_o = |(irqst_q & irqmsk_q);
    assign wake_o = sleep_i & |(evflag_q & en_vec & evsel_on);

    // ---------------------------------------------------------------
    // Read mux and acknowledge
    // ---------------------------------------------------------------
    always_comb begin
        rdat_d = '0;
        case (wb_adr_i)
            ACMP_OFS_CTRL1: rdat_d[7:0] = ctrl_q[0];
            ACMP_OFS_CTRL2: rdat_d[7:0] = ctrl_q[1];
            ACMP_OFS_CTRL3: rdat_d[7:0] = ctrl_q[2];
            ACMP_OFS_STAT: rdat_d[ACMP_NUM-1:0] = adj;
            ACMP_OFS_EVFLAG: rdat_d[ACMP_NUM-1:0] = evflag_q;
            ACMP_OFS_IRQST: rdat_d[ACMP_NUM-1:0] = irqst_q;
            ACMP_OFS_IRQMSK: rdat_d[ACMP_NUM-1:0] = irqmsk_q;
            default: rdat_d = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q <= req & ~ack_q;
            rdat_q <= rdat_d;
        end
    end

endmodule

// file: test/acmp_analog_model.sv
// Purpose: Analog side with fixed levels except the pin C level input, steered by the block
// Assumes: Higher level code means higher voltage
// Notes:   A disabled comparator drives low
`timescale 1ns/100ps
module acmp_analog_model
    import acmp_pkg::*;
#(parameter logic [3:0] VA = 4'h8, VL = 4'h6, VB = 4'h9, VD = 4'h3, VG = 4'h5)
(
    input acmp_analog_t [ACMP_NUM-1:0] analog_i, // Steering
    input wire logic [3:0] vc_i,                 // Pin C level
    output logic [ACMP_NUM-1:0] raw_o            // Raw results
);
    for (genvar i = 0; i < ACMP_NUM; i++) begin : g_cmp
        wire logic [1:0] r = analog_i[i].neg_route;
        wire logic [3:0] p = analog_i[i].pos_ladder ? VL : VA;
        wire logic [3:0] n = r == ACMP_ROUTE_BG ? VG : r == ACMP_ROUTE_D ? VD :
            r == ACMP_ROUTE_C ? vc_i : VB;
        assign raw_o[i] = analog_i[i].enable && p > n;
    end
endmodule

// file: test/acmp_ctrl_monitor.sv
// Purpose: Port-level checks of the comparator block
// Assumes: One clock, synchronous reset
// Notes:   Bound to every instance
`timescale 1ns/100ps
module acmp_ctrl_monitor
    import acmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ACMP_AW-1:0] wb_adr_i,
    input wire logic [ACMP_DW/8-1:0] wb_sel_i,
    input wire logic [ACMP_DW-1:0] wb_dat_i,
    input wire logic [ACMP_DW-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [ACMP_NUM-1:0] comparator_raw_i,
    input wire logic sleep_i,
    input acmp_analog_t [ACMP_NUM-1:0] analog_o,
    input wire logic [ACMP_NUM-1:0] result_pin_o,
    input wire logic [ACMP_NUM-1:0] result_pin_oe_o,
    input wire logic [ACMP_NUM-1:0] comparator_event_flag_o,
    input wire logic wake_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic wr = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire logic [7:0] d = wb_dat_i[7:0];
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    a_pin_when_enabled: assert property (!(|(result_pin_o & ~result_pin_oe_o)))
        else $error("pin driven while disabled");
    a_reset_steering: assert property ($fell(rst_i) |-> analog_o == {3{4'h7}})
        else $error("steering wrong after reset");
    a_any_sets_flag: assert property (wr && wb_adr_i == ACMP_OFS_CTRL1 && d[4:3] == 2'h3
        |=> comparator_event_flag_o[0])
        else $error("any-change select left flag clear");
    a_route_comp2: assert property (wr && wb_adr_i == ACMP_OFS_CTRL2 |=>
        analog_o[1] == {$past(d[7]), $past(d[2]), $past(d[0]) ? $past(d[1:0]) : $past(d[1:0]) ^ 2'h2})
        else $error("steering of comparator two wrong");
    a_flag_clear_write: assert property ($fell(comparator_event_flag_o[0]) |->
        $past(wr && wb_adr_i == ACMP_OFS_EVFLAG && !d[0]))
        else $error("flag cleared without a write");
    a_status_upper_zero: assert property (wb_ack_o && wb_adr_i == ACMP_OFS_STAT
        |-> wb_dat_o[31:3] == 29'h0)
        else $error("status upper bits set");
    a_wake_in_sleep: assert property (wake_o |-> sleep_i && |comparator_event_flag_o)
        else $error("wake without sleep and flag");
    c_any_mode: cover property (wr && wb_adr_i == ACMP_OFS_CTRL1 && d[4:3] == 2'h3);
    c_irq: cover property (irq_o);
    c_wake: cover property (wake_o);
endmodule
bind acmp_ctrl acmp_ctrl_monitor u_mon (.*);

// file: test/acmp_ctrl_tb_top.sv
// Purpose: Register-level test of the comparator block
// Assumes: Levels of the analog model at their defaults
// Notes:   Comparator one carries the event tests
`timescale 1ns/100ps
`define CK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
end
module acmp_ctrl_tb_top
    import acmp_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [ACMP_AW-1:0] wb_adr_i = 5'h00;
    logic [ACMP_DW/8-1:0] wb_sel_i = 4'hF;
    logic [ACMP_DW-1:0] wb_dat_i = 32'h0;
    logic [ACMP_DW-1:0] wb_dat_o;
    logic [ACMP_DW-1:0] q;
    logic wb_ack_o, wake_o, irq_o;
    logic [ACMP_NUM-1:0] comparator_raw_i, result_pin_o, result_pin_oe_o, comparator_event_flag_o;
    acmp_analog_t [ACMP_NUM-1:0] analog_o;
    logic [3:0] vc = 4'h7;
    logic [7:0] c;
    int error_cnt = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    acmp_ctrl dut (.*);
    acmp_analog_model model (.analog_i(analog_o), .vc_i(vc), .raw_o(comparator_raw_i));
    task automatic give_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic xf(input logic w, input logic [4:0] a, input logic [31:0] v);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= v;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 9) begin
                error_cnt++;
                give_verdict();
            end
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Expected status word from the model levels
    function automatic logic [31:0] ex(int i, logic [7:0] k);
        logic [3:0] n;
        n = k[1:0] == 2'h3 ? 4'h5 : k[1:0] == 2'h1 ? vc : i == 1 && k[1:0] == 2'h0 ? 4'h3 : 4'h9;
        return k[7] ? 32'(((k[2] ? 4'h6 : 4'h8) > n) ^ k[5]) << i : 32'h0;
    endfunction
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            xf(1'b0, 5'(4 * i), 32'h0);
            `CK(q, i < 3 ? 32'h1F : 32'h0)
        end
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 16; k++) begin
                c = {1'b1, k[0], k[3], 2'h0, k[2:0]};
                xf(1'b1, 5'(4 * i), 32'(c));
                repeat (4) @(posedge clk_i);
                xf(1'b0, 5'(4 * i), 32'h0);
                `CK(q, 32'(c))
                xf(1'b0, ACMP_OFS_STAT, 32'h0);
                `CK(q, ex(i, c))
                `CK(result_pin_o, c[6] ? 3'(ex(i, c)) : 3'h0)
                `CK(result_pin_oe_o, 3'(c[6]) << i)
            end
            xf(1'b1, 5'(4 * i), 32'h0);
        end
        sleep_i <= 1'b1;
        xf(1'b1, ACMP_OFS_IRQMSK, 32'h7);
        for (int e = 0; e < 4; e++) begin
            vc <= 4'h9;
            xf(1'b1, ACMP_OFS_CTRL1, 32'({3'h4, 2'(e), 3'h1}));
            repeat (4) @(posedge clk_i);
            xf(1'b0, ACMP_OFS_EVFLAG, 32'h0);
            `CK(q, 32'(e == 3))
            for (int s = 1; s >= 0; s--) begin
                xf(1'b1, ACMP_OFS_EVFLAG, 32'h0);
                xf(1'b1, ACMP_OFS_IRQST, 32'h7);
                vc <= s ? 4'h7 : 4'h9;
                repeat (6) @(posedge clk_i);
                `CK(comparator_event_flag_o, 3'(s ? e[0] : e[1]))
                `CK(irq_o, s ? e[0] : e[1])
                `CK(wake_o, s ? e[0] : e[1])
            end
            xf(1'b1, ACMP_OFS_EVFLAG, 32'h0);
        end
        `CK(irq_o, 1'b1)
        xf(1'b1, ACMP_OFS_IRQMSK, 32'h0);
        `CK(irq_o, 1'b0)
        // Inverted result, rise mode, mask off: only a falling raw result flags
        xf(1'b1, ACMP_OFS_CTRL1, 32'({3'h5, ACMP_EV_RISE, 3'h1}));
        repeat (4) @(posedge clk_i);
        xf(1'b1, ACMP_OFS_EVFLAG, 32'h0);
        for (int s = 1; s >= 0; s--) begin
            vc <= s ? 4'h7 : 4'h9;
            repeat (6) @(posedge clk_i);
            `CK(comparator_event_flag_o, 3'(!s))
        end
        `CK(irq_o, 1'b0)
        `CK(wake_o, 1'b1)
        sleep_i <= 1'b0;
        @(posedge clk_i);
        `CK(wake_o, 1'b0)
        xf(1'b1, ACMP_OFS_EVFLAG, 32'h4);
        `CK(comparator_event_flag_o, 3'h4)
        give_verdict();
    end
endmodule
